// ===== hdl/sac_anti_clip.sv
/*
 * Speaker anti-clip gain control: headroom detection, attack and decay
 * of a 0.5 dB attenuation applied at zero crossings.
 * Assumes synchronous inputs, a zero-cross pulse from the gain stage and
 * a power-limit flag from the neighbouring detector.
 */
// Operation
// - Headroom is supply minus level; below threshold requests attenuation.
// - Bit 15 enables detection, resets to one, zero disables requests.
// - Threshold field bits 11:8, resets to 0110 meaning 100 mV.
// - Threshold codes span -200 mV to 800 mV, 50 mV steps low.
// - Anti-clip triggered reduction uses the attack field rate.
// - After the violation clears, gain recovers at the decay field rate.
// - Concurrent power limit: clip attack rate, power-limit decay rate.
// - Attack field bits 6:4, reset 100; 000 is 0.6, 111 is 34.1 ms.
// - Attack codes 001 to 110 give 5.4 to 29.4 ms per 6 dB.
// - Decay field bits 2:0, reset 000; 120 ms up to 4100 ms.
// - Decay codes 001 to 110 give 480 to 2730 ms per 6 dB.
// - Everything acts only while the master gain control enable is set.
// - Gain changes only at zero crossings; ramp picks one or many steps.
// - Steps are 0.5 dB; never above volume, never below the floor.
`timescale 1ns/1ps
`default_nettype none
module sac_anti_clip #(
    parameter int ATK_CYC [8] = sac_pkg::SAC_ATK_CYC,
    parameter int DCY_CYC [8] = sac_pkg::SAC_DCY_CYC,
    parameter int PDCY_CYC [8] = sac_pkg::SAC_PDCY_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    input wire logic gainControlMasterEnable,
    input wire logic singleStepPerCrossing,
    input wire logic [sac_pkg::SAC_VOL_W-1:0] gainFloorCode,
    input wire logic [sac_pkg::SAC_VOL_W-1:0] speakerVolumeCode,
    input wire logic [2:0] powerLimitDecayRate,
    input wire logic powerLimitActive,
    input wire logic [sac_pkg::SAC_MV_W-1:0] speakerSupplyMv,
    input wire logic [sac_pkg::SAC_MV_W-1:0] outputLevelMv,
    input wire logic zeroCross,
    output logic [sac_pkg::SAC_ATT_W-1:0] speakerGainHalfDb,
    output logic [sac_pkg::SAC_ATT_W-1:0] attenuationHalfDb,
    output logic headroomViolation,
    output logic clipAttackActive
);
    import sac_pkg::*;

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic [15:0] ctrl_r;
    logic [15:0] rdData_r;
    wire ctrlHit = (regAddr == SAC_CTRL_OFS);
    wire headroomGuardEnable = ctrl_r[SAC_ENA_BIT];
    wire [3:0] headroomThresholdCode = ctrl_r[SAC_THR_LSB +: 4];
    wire [2:0] headroomAttackRate = ctrl_r[SAC_ATK_LSB +: 3];
    wire [2:0] headroomDecayRate = ctrl_r[SAC_DCY_LSB +: 3];

    // Writes keep only defined bits; reads of other addresses give zero
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= SAC_CTRL_RST;
            rdData_r <= '0;
        end else if (ce) begin
            if (regWrEn && ctrlHit) begin
                ctrl_r <= regWrData & SAC_CTRL_MASK;
            end
            if (regRdEn) begin
                rdData_r <= ctrlHit ? ctrl_r : 16'h0000;
            end
        end
    end
    assign regRdData = rdData_r;

    // ****************************************************************
    // Headroom detection
    // ****************************************************************
    wire signed [SAC_HR_W-1:0] headroomMv =
        $signed({1'b0, speakerSupplyMv}) - $signed({1'b0, outputLevelMv});
    wire signed [SAC_HR_W-1:0] thresholdMv =
        SAC_THR_MV[headroomThresholdCode];
    wire clipDetect = gainControlMasterEnable && headroomGuardEnable
        && (headroomMv < thresholdMv);

    // ****************************************************************
    // Gain limits in 0.5 dB units
    // ****************************************************************
    wire [SAC_ATT_W-1:0] volHalf = {1'b0, speakerVolumeCode} << 1;
    wire [SAC_ATT_W-1:0] floorHalf = {1'b0, gainFloorCode} << 1;
    wire [SAC_ATT_W-1:0] maxAtten =
        (volHalf > floorHalf) ? volHalf - floorHalf : '0;

    // ****************************************************************
    // State machine
    // ****************************************************************
    sac_state_t state_r;
    sac_state_t stateNxt;
    logic [SAC_ATT_W-1:0] atten_r;
    logic [SAC_ATT_W-1:0] attenNxt;
    logic pwrSeen_r;

    // Next state from detection and remaining attenuation
    always_comb begin
        stateNxt = state_r;
        case (state_r)
            SAC_IDLE: begin
                if (clipDetect) begin
                    stateNxt = SAC_ATTACK;
                end
            end
            SAC_ATTACK: begin
                if (!clipDetect) begin
                    stateNxt = (attenNxt != '0) ? SAC_DECAY : SAC_IDLE;
                end
            end
            SAC_DECAY: begin
                if (clipDetect) begin
                    stateNxt = SAC_ATTACK;
                end else if (atten_r == '0) begin
                    stateNxt = SAC_IDLE;
                end
            end
            default: begin
                stateNxt = SAC_IDLE;
            end
        endcase
        if (!gainControlMasterEnable) begin
            stateNxt = SAC_IDLE;
        end
    end

    // ****************************************************************
    // Step timer and rate selection
    // ****************************************************************
    wire inAttack = (state_r == SAC_ATTACK);
    wire inDecay = (state_r == SAC_DECAY);
    wire stateChange = (stateNxt != state_r);
    wire useClipDecay = !(pwrSeen_r || powerLimitActive);
    wire [SAC_TMR_W-1:0] atkPeriod =
        SAC_TMR_W'(ATK_CYC[headroomAttackRate]);
    wire [SAC_TMR_W-1:0] dcyPeriod = useClipDecay
        ? SAC_TMR_W'(DCY_CYC[headroomDecayRate])
        : SAC_TMR_W'(PDCY_CYC[powerLimitDecayRate]);
    wire [SAC_TMR_W-1:0] stepPeriod = inAttack ? atkPeriod : dcyPeriod;
    wire stepTick;

    // Restart on every transition, so a new violation times afresh
    sac_step_timer u_timer (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .run(inAttack || inDecay),
        .restart(stateChange),
        .period(stepPeriod),
        .tick(stepTick)
    );

    // ****************************************************************
    // Pending steps, applied at zero crossings
    // ****************************************************************
    logic [SAC_PEND_W-1:0] pend_r;
    logic [SAC_PEND_W-1:0] pendNxt;
    wire pendFull = (pend_r == {SAC_PEND_W{1'b1}});
    wire [SAC_PEND_W-1:0] applied = !zeroCross ? '0
        : (singleStepPerCrossing && pend_r != '0) ? SAC_PEND_W'(1)
        : pend_r;
    wire [SAC_ATT_W-1:0] appliedW = SAC_ATT_W'(applied);
    wire [SAC_ATT_W:0] attenUp = {1'b0, atten_r} + {1'b0, appliedW};

    // Tick counted in the same cycle as a crossing is not lost
    always_comb begin
        pendNxt = pend_r - applied;
        if (stepTick && !pendFull) begin
            pendNxt = pendNxt + 1'b1;
        end
        if (stateChange) begin
            pendNxt = '0;
        end
    end

    // Attenuation moves only by applied steps, within the limits
    always_comb begin
        attenNxt = atten_r;
        if (inAttack) begin
            attenNxt = (attenUp > {1'b0, maxAtten}) ? maxAtten
                : attenUp[SAC_ATT_W-1:0];
        end else if (inDecay) begin
            attenNxt = (appliedW >= atten_r) ? '0
                : atten_r - appliedW;
        end
        if (attenNxt > maxAtten) begin
            attenNxt = maxAtten;
        end
        if (!gainControlMasterEnable) begin
            attenNxt = '0;
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= SAC_IDLE;
            atten_r <= '0;
            pend_r <= '0;
            pwrSeen_r <= 1'b0;
        end else if (ce) begin
            state_r <= stateNxt;
            atten_r <= attenNxt;
            pend_r <= pendNxt;
            if (stateNxt == SAC_IDLE) begin
                pwrSeen_r <= 1'b0;
            end else if (inAttack && powerLimitActive) begin
                pwrSeen_r <= 1'b1;
            end
        end
    end

    // Registered status and gain to the speaker stage
    logic [SAC_ATT_W-1:0] gain_r;
    logic viol_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            gain_r <= '0;
            viol_r <= 1'b0;
        end else if (ce) begin
            gain_r <= volHalf - attenNxt;
            viol_r <= clipDetect;
        end
    end
    assign speakerGainHalfDb = gain_r;
    assign attenuationHalfDb = atten_r;
    assign headroomViolation = viol_r;
    assign clipAttackActive = inAttack;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_violation_starts_attack;
        @(posedge clk) disable iff (srst)
        ce && clipDetect |=> state_r == SAC_ATTACK;
    endproperty
    a_violation_starts_attack: assert property (p_violation_starts_attack)
        else $error("violation did not start attack");

    property p_guard_off;
        @(posedge clk) disable iff (srst)
        ce && (!headroomGuardEnable || !gainControlMasterEnable)
            |=> !headroomViolation;
    endproperty
    a_guard_off: assert property (p_guard_off)
        else $error("detection while disabled");

    property p_thr_default;
        @(posedge clk) disable iff (srst)
        headroomThresholdCode == SAC_THR_100MV |-> thresholdMv == 14'sd100;
    endproperty
    a_thr_default: assert property (p_thr_default)
        else $error("threshold code 0110 is not 100 mV");

    property p_attack_period;
        @(posedge clk) disable iff (srst)
        inAttack |-> stepPeriod == SAC_TMR_W'(ATK_CYC[headroomAttackRate]);
    endproperty
    a_attack_period: assert property (p_attack_period)
        else $error("attack rate not from attack field");

    property p_concurrent_decay;
        @(posedge clk) disable iff (srst)
        inDecay && pwrSeen_r |->
            stepPeriod == SAC_TMR_W'(PDCY_CYC[powerLimitDecayRate]);
    endproperty
    a_concurrent_decay: assert property (p_concurrent_decay)
        else $error("concurrent decay not at power-limit rate");

    property p_master_off;
        @(posedge clk) disable iff (srst)
        ce && !gainControlMasterEnable |=> atten_r == '0 && !inAttack;
    endproperty
    a_master_off: assert property (p_master_off)
        else $error("attenuation while master off");

    property p_zero_cross_only;
        @(posedge clk) disable iff (srst)
        ce && !zeroCross && gainControlMasterEnable && atten_r <= maxAtten
            && $stable(maxAtten) |=> $stable(atten_r);
    endproperty
    a_zero_cross_only: assert property (p_zero_cross_only)
        else $error("gain moved without zero crossing");

    property p_single_step;
        @(posedge clk) disable iff (srst)
        ce && singleStepPerCrossing && gainControlMasterEnable
            && atten_r <= maxAtten && $stable(maxAtten) |=>
            atten_r - $past(atten_r) <= 7'h01
            || $past(atten_r) - atten_r <= 7'h01;
    endproperty
    a_single_step: assert property (p_single_step)
        else $error("more than one step per crossing");

    property p_limits;
        @(posedge clk) disable iff (srst)
        ce |=> atten_r <= $past(maxAtten);
    endproperty
    a_limits: assert property (p_limits)
        else $error("attenuation beyond floor");

    property p_decay_ends;
        @(posedge clk) disable iff (srst)
        ce && inDecay && atten_r == '0 && !clipDetect
            |=> state_r == SAC_IDLE;
    endproperty
    a_decay_ends: assert property (p_decay_ends)
        else $error("decay did not stop at volume");

endmodule
`default_nettype wire

// ===== hdl/sac_pkg.sv
/*
 * Constants, field layout and rate tables of the speaker anti-clip gain
 * control. Assumes a 200 MHz block clock; levels arrive in millivolts.
 */
package sac_pkg;

    // ****************************************************************
    // Clock and step geometry
    // ****************************************************************
    localparam int SAC_CLK_MHZ = 200;
    localparam int SAC_STEPS_PER_6DB = 12;  // 6 dB in 0.5 dB steps
    localparam int SAC_TMR_W = 27;
    localparam int SAC_MV_W = 13;
    localparam int SAC_HR_W = 14;
    localparam int SAC_VOL_W = 6;
    localparam int SAC_ATT_W = 7;           // Attenuation in 0.5 dB units
    localparam int SAC_PEND_W = 4;

    // ****************************************************************
    // Control register
    // ****************************************************************
    localparam logic [7:0] SAC_CTRL_OFS = 8'h62;
    localparam int SAC_ENA_BIT = 15;
    localparam int SAC_THR_LSB = 8;
    localparam int SAC_ATK_LSB = 4;
    localparam int SAC_DCY_LSB = 0;
    localparam logic [15:0] SAC_CTRL_MASK = 16'h8f77;
    localparam logic [15:0] SAC_CTRL_RST = 16'h8640;
    localparam logic [3:0] SAC_THR_100MV = 4'h6;

    // ****************************************************************
    // Headroom thresholds in mV, indexed by code
    // ****************************************************************
    localparam logic signed [SAC_HR_W-1:0] SAC_THR_MV [16] = '{
        -14'sd200, -14'sd150, -14'sd100, -14'sd50, 14'sd0, 14'sd50,
        14'sd100, 14'sd150, 14'sd200, 14'sd250, 14'sd300, 14'sd400,
        14'sd500, 14'sd600, 14'sd700, 14'sd800};

    // ****************************************************************
    // Rates in microseconds per 6 dB, and cycles per 0.5 dB step
    // ****************************************************************
    typedef int sac_tbl_t [8];
    localparam sac_tbl_t SAC_ATK_US = '{600, 5400, 10200, 15000, 19800,
        24600, 29400, 34100};
    localparam sac_tbl_t SAC_DCY_US = '{120000, 480000, 820000, 1170000,
        1640000, 2050000, 2730000, 4100000};
    localparam sac_tbl_t SAC_PDCY_US = '{1080000, 1200000, 1320000,
        1680000, 2040000, 2760000, 4080000, 4080000};

    function automatic sac_tbl_t sac_to_cycles(sac_tbl_t us);
        sac_tbl_t c;
        for (int i = 0; i < 8; i++) begin
            c[i] = us[i] * SAC_CLK_MHZ / SAC_STEPS_PER_6DB;
            if (c[i] < 1) begin
                c[i] = 1;
            end
        end
        return c;
    endfunction

    localparam sac_tbl_t SAC_ATK_CYC = sac_to_cycles(SAC_ATK_US);
    localparam sac_tbl_t SAC_DCY_CYC = sac_to_cycles(SAC_DCY_US);
    localparam sac_tbl_t SAC_PDCY_CYC = sac_to_cycles(SAC_PDCY_US);

    // ****************************************************************
    // Gain control states
    // ****************************************************************
    typedef enum logic [2:0] {
        SAC_IDLE = 3'b001,
        SAC_ATTACK = 3'b010,
        SAC_DECAY = 3'b100
    } sac_state_t;

endpackage

// ===== hdl/sac_step_timer.sv
/*
 * Step timer: one tick every period cycles while running.
 * Assumes period is at least one and is held while running.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_step_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic run,
    input wire logic restart,
    input wire logic [sac_pkg::SAC_TMR_W-1:0] period,
    output logic tick
);
    import sac_pkg::*;

    logic [SAC_TMR_W-1:0] count_r;
    wire atZero = (count_r == '0);

    // Tick at the end of each period
    assign tick = run && !restart && atZero;

    // Reload on restart, idle or expiry, otherwise count down
    always_ff @(posedge clk) begin
        if (srst) begin
            count_r <= '0;
        end else if (ce) begin
            if (restart || !run || atZero) begin
                count_r <= period - 1'b1;
            end else begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== test/sac_gain_stage_model.sv
/*
 * Model of the speaker gain stage and supply that feed the
 * anti-clip block. Assumes the bench commands the level and crossing gap.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_gain_stage_model #(
    parameter int SUPPLY_MV = 3000
) (
    input wire logic clk,
    input wire logic [sac_pkg::SAC_MV_W-1:0] levelCmdMv,
    input wire logic [7:0] crossGap,
    output logic [sac_pkg::SAC_MV_W-1:0] speakerSupplyMv,
    output logic [sac_pkg::SAC_MV_W-1:0] outputLevelMv,
    output logic zeroCross
);
    import sac_pkg::*;
    logic [7:0] gapCnt_r;
    // Supply stays put, level follows the command one edge late
    always_ff @(posedge clk) begin
        speakerSupplyMv <= SAC_MV_W'(SUPPLY_MV);
        outputLevelMv <= levelCmdMv;
    end
    // One-cycle crossing pulse every crossGap cycles, none at gap zero
    always_ff @(posedge clk) begin
        if (crossGap == 8'h00) begin
            zeroCross <= 1'b0;
            gapCnt_r <= 8'h00;
        end else if (gapCnt_r == 8'h00) begin
            zeroCross <= 1'b1;
            gapCnt_r <= crossGap - 8'h01;
        end else begin
            zeroCross <= 1'b0;
            gapCnt_r <= gapCnt_r - 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
/*
 * Self-checking bench of the speaker anti-clip gain control.
 * Assumes the gain stage model and shortened per-step cycle tables.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sac_pkg::*;
    localparam int ATK [8] = '{4, 6, 8, 10, 12, 14, 16, 18};
    localparam int DCY [8] = '{20, 22, 24, 26, 28, 30, 32, 34};
    localparam int PDCY [8] = '{36, 38, 40, 42, 44, 46, 48, 50};
    localparam int VOL = 40;
    logic clk, srst, ce, regWrEn, regRdEn, masterEna, oneStep, plActive;
    logic zeroCross, violation, attackAct;
    logic [7:0] regAddr, crossGap;
    logic [15:0] regWrData, regRdData, rd, wd;
    logic [5:0] floorCode;
    logic [2:0] plDecay;
    logic [12:0] supplyMv, levelMv, levelCmdMv;
    logic [6:0] gainHd, attHd;
    int errTotal, samplesChecked, cyc, seed, expAtt, t0;

    sac_anti_clip #(.ATK_CYC(ATK), .DCY_CYC(DCY), .PDCY_CYC(PDCY)) i_dut (
        .clk(clk), .srst(srst), .ce(ce), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .gainControlMasterEnable(masterEna),
        .singleStepPerCrossing(oneStep), .gainFloorCode(floorCode),
        .speakerVolumeCode(6'(VOL)), .powerLimitDecayRate(plDecay),
        .powerLimitActive(plActive), .speakerSupplyMv(supplyMv),
        .outputLevelMv(levelMv), .zeroCross(zeroCross),
        .speakerGainHalfDb(gainHd), .attenuationHalfDb(attHd),
        .headroomViolation(violation), .clipAttackActive(attackAct));
    sac_gain_stage_model i_model (
        .clk(clk), .levelCmdMv(levelCmdMv), .crossGap(crossGap),
        .speakerSupplyMv(supplyMv), .outputLevelMv(levelMv),
        .zeroCross(zeroCross));

    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic complete_run();
        $display("checks %0d errors %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rdreg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic do_reset();
        @(posedge clk);
        srst <= 1'b1;
        masterEna <= 1'b1;
        levelCmdMv <= 13'd2800;
        crossGap <= 8'd2;
        floorCode <= 6'h00;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
    endtask
    // Bounded wait for the next attenuation step
    task automatic wait_change();
        logic [6:0] old;
        int n;
        old = attHd;
        n = 0;
        while (attHd === old && n < 300) begin
            settle(1);
            n++;
        end
        if (n == 300) check("step wait", 16'h0, 16'h1);
    endtask
    // Spacing of steps in steady state, and the gain that goes with them
    task automatic step_rate(input string what, input int dir,
            input int per);
        wait_change();
        wait_change();
        t0 = cyc;
        expAtt = int'(attHd);
        wait_change();
        expAtt = expAtt + dir;
        check({what, " period"}, 16'(cyc - t0), 16'(per));
        check({what, " atten"}, 16'(attHd), 16'(expAtt));
        check({what, " gain"}, 16'(gainHd), 16'(2 * VOL - expAtt));
    endtask
    task automatic run_case(input int a, input int d, input int pl);
        wr(8'h62, 16'(16'h8600 | (a << 4) | d));
        plActive <= 1'(pl);
        plDecay <= 3'(d);
        levelCmdMv <= 13'd2950;
        step_rate("attack", 1, ATK[a]);
        check("attack state", 16'(attackAct), 16'h1);
        repeat (40) @(posedge clk);
        levelCmdMv <= 13'd2800;
        step_rate("decay", -1, pl ? PDCY[d] : DCY[d]);
    endtask
    task automatic pulse_cross();
        @(posedge clk);
        crossGap <= 8'd200;
        repeat (2) @(posedge clk);
        crossGap <= 8'h00;
        settle(4);
    endtask
    function automatic int thr_mv(input int c);
        return (c <= 10) ? 50 * c - 200 : 100 * c - 700;
    endfunction

    // Watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        errTotal++;
        complete_run();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        {regWrEn, regRdEn, masterEna, oneStep, plActive} = 5'h00;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        floorCode = 6'h00;
        plDecay = 3'h0;
        levelCmdMv = 13'd2800;
        crossGap = 8'h00;
        {errTotal, samplesChecked, cyc, expAtt, t0} = '0;
        seed = 72544;
        do_reset();
        rdreg(8'h62, rd);
        check("ctrl reset", rd, 16'h8640);
        for (int i = 0; i < 4; i++) begin
            wd = 16'($random(seed));
            wr(8'h62, wd);
            rdreg(8'h62, rd);
            check("ctrl rw", rd, wd & 16'h8f77);
        end
        wr(8'h63, 16'hffff);
        rdreg(8'h63, rd);
        check("unmapped", rd, 16'h0000);
        rdreg(8'h62, rd);
        check("ctrl kept", rd, wd & 16'h8f77);
        crossGap <= 8'h00;
        for (int c = 0; c < 16; c++) begin
            wr(8'h62, 16'(16'h8040 | (c << 8)));
            levelCmdMv <= 13'(3001 - thr_mv(c));
            settle(4);
            check("below thr", 16'(violation), 16'h1);
            @(posedge clk);
            levelCmdMv <= 13'(3000 - thr_mv(c));
            settle(4);
            check("at thr", 16'(violation), 16'h0);
        end
        wr(8'h62, 16'h0640);
        levelCmdMv <= 13'd2950;
        settle(4);
        check("guard off", 16'(violation), 16'h0);
        wr(8'h62, 16'h8640);
        masterEna <= 1'b0;
        settle(4);
        check("master off", 16'({violation, attackAct}), 16'h0);
        do_reset();
        for (int i = 0; i < 8; i++) run_case(i, i, 0);
        run_case(2, 3, 1);
        @(posedge clk);
        plActive <= 1'b0;
        for (int n = 0; n < 3000 && attHd !== 7'h00; n++) settle(1);
        settle(100);
        check("rest atten", 16'(attHd), 16'h0);
        check("rest gain", 16'(gainHd), 16'(2 * VOL));
        do_reset();
        wr(8'h62, 16'h8600);
        floorCode <= 6'(VOL - 2);
        levelCmdMv <= 13'd2950;
        settle(200);
        check("floor atten", 16'(attHd), 16'h4);
        check("floor gain", 16'(gainHd), 16'(2 * VOL - 4));
        @(posedge clk);
        masterEna <= 1'b0;
        settle(4);
        check("master clear", 16'(attHd), 16'h0);
        check("master gain", 16'(gainHd), 16'(2 * VOL));
        do_reset();
        wr(8'h62, 16'h8640);
        crossGap <= 8'h00;
        oneStep <= 1'b1;
        levelCmdMv <= 13'd2950;
        settle(100);
        pulse_cross();
        check("one step", 16'(attHd), 16'h1);
        @(posedge clk);
        ce <= 1'b0;
        pulse_cross();
        check("ce freeze", 16'(attHd), 16'h1);
        @(posedge clk);
        ce <= 1'b1;
        oneStep <= 1'b0;
        pulse_cross();
        check("many steps", 16'(attHd >= 6 && attHd <= 16), 16'h1);
        complete_run();
    end
endmodule
`default_nettype wire
